// ### core/tmr3_defines.svh
// constants for the three channel timer control block
// Operation
// RULE_01: pin direction bit 0: 0 makes pin an input, 1 drives rtc tick out.
// RULE_02: pin direction register resets to zero, kept through standby.
// RULE_03: reserved bits read zero; software writes zero there.
// RULE_04: run bits 2..0 halt channel at 0, count at 1; reset to 0.
// RULE_05: run register clears on reset; rtc-clocked channels keep run in standby.
// RULE_06: in standby, pll change or module stop clears run for non-rtc channels.
// RULE_07: channel control registers reset to zero and persist through standby.
// RULE_08: channel 2 capture flag bit 9 sets on capture; write 0 clears.
// RULE_09: underflow flag bit 8 sets on underflow; write 0 clears, 1 ignored.
// RULE_10: capture control 00 off, 10 on without irq, 11 on with irq.
// RULE_11: software sets pin as input before using capture.
// RULE_12: on selected pin edge, channel 2 counter copies into capture register.
// RULE_13: underflow irq enable bit 5 gates underflow flag onto request.
// RULE_14: edge select bits 4..3: 00 rising, 01 falling, 1x both edges.
// RULE_15: prescale 000..011 clock/4,16,64,256; 100 rtc tick; 101 pin input.
// RULE_16: software never writes prescale 110, 111 or capture control 01.
// RULE_17: software sets port mode bits to 00 before using timer pin.
// RULE_18: running counter decrements; at zero reloads, sets underflow, keeps going.
// RULE_19: a 32-bit counter read returns one coherent buffered value.
// RULE_20: irq levels: flag and enable; capture irq: flag and code 11.
`ifndef TMR3_DEFINES_SVH
`define TMR3_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define TMR3_OFS_DIR 8'h00
`define TMR3_OFS_RUN 8'h02
`define TMR3_OFS_RELOAD0 8'h04
`define TMR3_OFS_COUNT0 8'h08
`define TMR3_OFS_CTRL0 8'h0c
`define TMR3_CHAN_STRIDE 8'h0c
`define TMR3_OFS_CAPTURE 8'h28

// ************************************************************
// field positions
// ************************************************************
`define TMR3_BIT_PIN_OUT 0
`define TMR3_BIT_CAP_FLAG 9
`define TMR3_BIT_UNF 8
`define TMR3_BIT_CAP_HI 7
`define TMR3_BIT_CAP_LO 6
`define TMR3_BIT_UNDERFLOW_IRQ_ENABLE 5
`define TMR3_BIT_EDGE_HI 4
`define TMR3_BIT_EDGE_LO 3
`define TMR3_PSC_MSB 2
`define TMR3_PSC_LSB 0

// ************************************************************
// masks and reset values
// ************************************************************
`define TMR3_MASK_DIR 8'h01
`define TMR3_MASK_RUN 8'h07
`define TMR3_MASK_CTRL01 16'h013f
`define TMR3_MASK_CTRL2 16'h03ff
`define TMR3_RST_DIR 8'h00
`define TMR3_RST_RUN 8'h00
`define TMR3_RST_CTRL 16'h0000
`define TMR3_RST_COUNT 32'hffffffff
`define TMR3_RST_CAPTURE 32'h00000000
`define TMR3_RST_DIV 8'h00

`endif

// ### core/tmr3_pkg.sv
// types shared by the three channel timer control block
package tmr3_pkg;

  // register bus request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } tmr3_bus_req_t;

  // standby side controls
  typedef struct packed {
    logic standbyMode;
    logic pllRatioChange;
    logic moduleStop;
  } tmr3_standby_t;

  // count clock sources
  typedef enum logic [2:0] {
    TMR3_PSC_DIV4 = 3'b000,
    TMR3_PSC_DIV16 = 3'b001,
    TMR3_PSC_DIV64 = 3'b010,
    TMR3_PSC_DIV256 = 3'b011,
    TMR3_PSC_RTC = 3'b100,
    TMR3_PSC_PIN = 3'b101
  } tmr3_psc_t;

endpackage : tmr3_pkg

// ### core/tmr3_timer.sv
// three channel down-counting timer with control, status and capture
`timescale 1ns/1ps
`include "tmr3_defines.svh"

module tmr3_timer #(
  parameter int CHANNELS = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire tmr3_pkg::tmr3_bus_req_t busReq,
  output logic [31:0] rdData,
  // timer pin and rtc tick
  input wire logic timerExtPinIn,
  output logic timerExtPinOut,
  output logic timerExtPinOe,
  input wire logic rtcTick,
  // standby controls
  input wire tmr3_pkg::tmr3_standby_t standby,
  // interrupt request levels
  output logic [CHANNELS-1:0] underflowIrq,
  output logic captureIrq
);
  import tmr3_pkg::*;

  localparam int CAP_CH = CHANNELS - 1;

  // ************************************************************
  // state
  // ************************************************************
  logic pinOutputSelect;
  logic [CHANNELS-1:0] runBits;
  logic [31:0] reloadValue [CHANNELS];
  logic [31:0] downCounter [CHANNELS];
  logic [15:0] ctrl [CHANNELS];
  logic [31:0] captureValue;
  logic [7:0] divCount;
  logic pinPrev;
  logic rtcPrev;
  logic pinRise;
  logic pinFall;
  logic rtcRise;
  logic [CHANNELS-1:0] countTick;
  logic [CHANNELS-1:0] underflowEvent;
  logic [CHANNELS-1:0] standbyClear;
  logic captureEvent;
  logic [7:0] next_addr;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] chanAddr(input logic [7:0] base,
                                          input int ch);
    chanAddr = base + 8'(ch) * `TMR3_CHAN_STRIDE;
  endfunction : chanAddr

  // selected pin edge seen this cycle
  function automatic logic edgeHit(input logic [15:0] c,
                                   input logic rise,
                                   input logic fall);
    logic hit;
    hit = 1'b0;
    if (c[`TMR3_BIT_EDGE_HI]) begin
      hit = rise | fall; // RULE_14
    end else if (c[`TMR3_BIT_EDGE_LO]) begin
      hit = fall; // RULE_14
    end else begin
      hit = rise; // RULE_14
    end
    edgeHit = hit;
  endfunction : edgeHit

  // count tick for a channel from its prescale field
  function automatic logic clockHit(input logic [15:0] c,
                                    input logic [7:0] div,
                                    input logic rtcEdge,
                                    input logic pinEdgeRise,
                                    input logic pinEdgeFall,
                                    input logic pinIsInput);
    logic hit;
    hit = 1'b0;
    case (c[`TMR3_PSC_MSB:`TMR3_PSC_LSB])
      TMR3_PSC_DIV4: hit = &div[1:0]; // RULE_15
      TMR3_PSC_DIV16: hit = &div[3:0]; // RULE_15
      TMR3_PSC_DIV64: hit = &div[5:0]; // RULE_15
      TMR3_PSC_DIV256: hit = &div[7:0]; // RULE_15
      TMR3_PSC_RTC: hit = rtcEdge; // RULE_15
      TMR3_PSC_PIN: begin
        hit = pinIsInput & edgeHit(c, pinEdgeRise, pinEdgeFall); // RULE_15
      end
      // reserved codes never count
      default: hit = 1'b0;
    endcase
    clockHit = hit;
  endfunction : clockHit

  function automatic logic isRtcClocked(input logic [15:0] c);
    isRtcClocked = c[`TMR3_PSC_MSB:`TMR3_PSC_LSB] == TMR3_PSC_RTC;
  endfunction : isRtcClocked

  function automatic logic [15:0] ctrlMask(input int ch);
    ctrlMask = (ch == CAP_CH) ? `TMR3_MASK_CTRL2 : `TMR3_MASK_CTRL01;
  endfunction : ctrlMask

  // write strobe aimed at one register offset
  function automatic logic wrHit(input tmr3_bus_req_t req,
                                 input logic [7:0] ofs);
    wrHit = req.wrStrobe && req.addr == ofs;
  endfunction : wrHit

  // ************************************************************
  // pin and rtc edge detection
  // ************************************************************
  // pin taken as synchronous: a noisy pin can count twice
  // history flops start at the idle low level, so no false edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinPrev <= 1'b0;
      rtcPrev <= 1'b0;
    end else begin
      pinPrev <= timerExtPinIn;
      rtcPrev <= rtcTick;
    end
  end

  always_comb begin
    pinRise = timerExtPinIn & ~pinPrev;
    pinFall = ~timerExtPinIn & pinPrev;
    rtcRise = rtcTick & ~rtcPrev;
  end

  // ************************************************************
  // prescaler
  // ************************************************************
  // one shared divider keeps all channels on a common phase
  // so a channel started mid-phase sees a short first period
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      divCount <= `TMR3_RST_DIV;
    end else begin
      divCount <= divCount + 8'h01;
    end
  end

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      countTick[i] = runBits[i] & clockHit(ctrl[i], divCount, rtcRise,
                                           pinRise, pinFall,
                                           ~pinOutputSelect); // RULE_04
      underflowEvent[i] = countTick[i] &&
                          downCounter[i] == 32'h00000000; // RULE_18
    end
    captureEvent = ctrl[CAP_CH][`TMR3_BIT_CAP_HI] &
                   edgeHit(ctrl[CAP_CH], pinRise, pinFall); // RULE_12
  end

  // ************************************************************
  // pin direction register
  // ************************************************************
  // standby has no effect here: only reset or a software write changes it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinOutputSelect <= 1'(`TMR3_RST_DIR); // RULE_02
    end else if (wrHit(busReq, `TMR3_OFS_DIR)) begin
      pinOutputSelect <= busReq.wrData[`TMR3_BIT_PIN_OUT];
    end
  end

  // pin drives the rtc tick only while selected as output
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timerExtPinOut <= 1'b0;
    end else begin
      timerExtPinOut <= rtcTick; // RULE_01
    end
  end

  assign timerExtPinOe = pinOutputSelect; // RULE_01

  // ************************************************************
  // run register
  // ************************************************************
  // pll change or module stop in standby drops non-rtc channels
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      standbyClear[i] = standby.standbyMode &&
                        (standby.pllRatioChange || standby.moduleStop) &&
                        !isRtcClocked(ctrl[i]); // RULE_06
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      runBits <= CHANNELS'(`TMR3_RST_RUN); // RULE_05
    end else begin
      if (wrHit(busReq, `TMR3_OFS_RUN)) begin
        runBits <= busReq.wrData[CHANNELS-1:0]; // RULE_04
      end
      // standby drop overrides a run write in the same cycle
      for (int i = 0; i < CHANNELS; i++) begin
        if (standbyClear[i]) begin
          runBits[i] <= 1'b0; // RULE_06
        end
      end
    end
  end

  // ************************************************************
  // reload and counter registers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < CHANNELS; i++) begin
        reloadValue[i] <= `TMR3_RST_COUNT;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (busReq.wrStrobe &&
            busReq.addr == chanAddr(`TMR3_OFS_RELOAD0, i)) begin
          reloadValue[i] <= busReq.wrData;
        end
      end
    end
  end

  // a software write beats a count in the same cycle
  // one period spans reload plus one ticks, zero included
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < CHANNELS; i++) begin
        downCounter[i] <= `TMR3_RST_COUNT;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (busReq.wrStrobe &&
            busReq.addr == chanAddr(`TMR3_OFS_COUNT0, i)) begin
          downCounter[i] <= busReq.wrData;
        end else if (underflowEvent[i]) begin
          downCounter[i] <= reloadValue[i]; // RULE_18
        end else if (countTick[i]) begin
          downCounter[i] <= downCounter[i] - 32'h00000001; // RULE_18
        end
      end
    end
  end

  // ************************************************************
  // channel control registers
  // ************************************************************
  // flags: hardware set wins over a clearing write in the same cycle
  // only the low byte is plain storage; flags obey their own rules
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < CHANNELS; i++) begin
        ctrl[i] <= `TMR3_RST_CTRL; // RULE_07
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (busReq.wrStrobe &&
            busReq.addr == chanAddr(`TMR3_OFS_CTRL0, i)) begin
          ctrl[i][7:0] <= busReq.wrData[7:0] & 8'(ctrlMask(i)); // RULE_03
          if (!busReq.wrData[`TMR3_BIT_UNF]) begin
            ctrl[i][`TMR3_BIT_UNF] <= 1'b0; // RULE_09
          end
          if (i == CAP_CH && !busReq.wrData[`TMR3_BIT_CAP_FLAG]) begin
            ctrl[i][`TMR3_BIT_CAP_FLAG] <= 1'b0; // RULE_08
          end
        end
        if (underflowEvent[i]) begin
          ctrl[i][`TMR3_BIT_UNF] <= 1'b1; // RULE_09
        end
        if (i == CAP_CH && captureEvent) begin
          ctrl[i][`TMR3_BIT_CAP_FLAG] <= 1'b1; // RULE_08
        end
      end
    end
  end

  // ************************************************************
  // capture register
  // ************************************************************
  // capture ignores the direction bit, unlike pin counting
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      captureValue <= `TMR3_RST_CAPTURE;
    end else if (captureEvent) begin
      captureValue <= downCounter[CAP_CH]; // RULE_12
    end
  end

  // ************************************************************
  // interrupt levels
  // ************************************************************
  // levels, not pulses: software clears the flag to drop them
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      underflowIrq[i] = ctrl[i][`TMR3_BIT_UNF] &
                        ctrl[i][`TMR3_BIT_UNDERFLOW_IRQ_ENABLE]; // RULE_13 RULE_20
    end
    captureIrq = ctrl[CAP_CH][`TMR3_BIT_CAP_FLAG] &
                 ctrl[CAP_CH][`TMR3_BIT_CAP_HI] &
                 ctrl[CAP_CH][`TMR3_BIT_CAP_LO]; // RULE_10 RULE_20
  end

  // ************************************************************
  // read port
  // ************************************************************
  // whole word latched in one edge, so both halves always match
  assign next_addr = busReq.addr;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdData <= 32'h00000000;
    end else if (busReq.rdStrobe) begin
      // unmapped offsets fall through and read zero
      rdData <= 32'h00000000; // RULE_03
      if (next_addr == `TMR3_OFS_DIR) begin
        rdData <= {31'h0, pinOutputSelect};
      end
      if (next_addr == `TMR3_OFS_RUN) begin
        rdData <= {{(32-CHANNELS){1'b0}}, runBits};
      end
      if (next_addr == `TMR3_OFS_CAPTURE) begin
        rdData <= captureValue;
      end
      for (int i = 0; i < CHANNELS; i++) begin
        if (next_addr == chanAddr(`TMR3_OFS_RELOAD0, i)) begin
          rdData <= reloadValue[i];
        end
        if (next_addr == chanAddr(`TMR3_OFS_COUNT0, i)) begin
          rdData <= downCounter[i]; // RULE_19
        end
        if (next_addr == chanAddr(`TMR3_OFS_CTRL0, i)) begin
          rdData <= {16'h0000, ctrl[i] & ctrlMask(i)}; // RULE_03
        end
      end
    end else begin
      rdData <= 32'h00000000;
    end
  end

endmodule : tmr3_timer

// ### verification/tb_tmr3_timer.sv
// self-checking testbench for the three channel timer block
`timescale 1ns/1ps
module tb_tmr3_timer;
  import tmr3_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  tmr3_bus_req_t busReq = '0;
  tmr3_standby_t standby = '0;
  logic timerExtPinIn = 1'b0;
  logic rtcTick = 1'b0;
  logic [31:0] rdData, d, w, r;
  logic timerExtPinOut, timerExtPinOe, captureIrq;
  logic [2:0] underflowIrq;
  logic [7:0] o;
  integer errorCnt = 0, testsRun = 0, seed = 31, i, k;

  always #25 sys_clk = ~sys_clk;

  tmr3_timer #(.CHANNELS(3)) DUT (.sys_clk(sys_clk), .reset(reset),
    .busReq(busReq), .rdData(rdData), .timerExtPinIn(timerExtPinIn),
    .timerExtPinOut(timerExtPinOut), .timerExtPinOe(timerExtPinOe),
    .rtcTick(rtcTick), .standby(standby), .underflowIrq(underflowIrq),
    .captureIrq(captureIrq));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] decExp(input int c);
    return 32'(1024 >> (2 + 2 * c));
  endfunction : decExp

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    testsRun++;
    if (s !== e) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: v, wrStrobe: 1'b1, rdStrobe: 1'b0};
    @(posedge sys_clk);
    busReq.wrStrobe <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: 32'h0, wrStrobe: 1'b0, rdStrobe: 1'b1};
    @(posedge sys_clk);
    busReq.rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask : rd

  task automatic pins(input logic p, input logic t);
    @(posedge sys_clk);
    timerExtPinIn <= p;
    rtcTick <= t;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : pins

  // three pulses on the pin (p=1) or on the tick (p=0), counter from 100
  task automatic pulses(input logic [31:0] c, input logic p);
    int n;
    wr(8'h0c, c);
    wr(8'h08, 32'h100);
    wr(8'h02, 32'h1);
    for (n = 0; n < 3; n++) begin
      pins(p, !p);
      pins(1'b0, 1'b0);
    end
    wr(8'h02, 32'h0);
    rd(8'h08);
  endtask : pulses

  task automatic stby(input logic [2:0] v);
    @(posedge sys_clk);
    standby <= v;
    @(posedge sys_clk);
    standby <= '0;
    #1;
  endtask : stby

  task automatic give_verdict;
    if (errorCnt == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    for (i = 0; i < 11; i++) begin
      rd(8'(i * 4));
      chk("reset value", d, (i > 0 && i < 10 && i % 3 != 0) ? '1 : '0);
    end
    rd(8'h02);
    chk("run reset", d, 32'h0);
    wr(8'h00, 32'hffffffff);
    rd(8'h00);
    chk("dir bits", d, 32'h1);
    chk("pin enable", {31'h0, timerExtPinOe}, 32'h1);
    wr(8'h02, 32'hffffffff);
    rd(8'h02);
    chk("run bits", d, 32'h7);
    wr(8'h0c, 32'hfffffef8);
    rd(8'h0c);
    chk("ctrl0 bits", d, 32'h38);
    wr(8'h24, 32'hfffffcf8);
    rd(8'h24);
    chk("ctrl2 bits", d, 32'hf8);
    wr(8'h30, 32'hffffffff);
    rd(8'h30);
    chk("unmapped", d, 32'h0);
    wr(8'h00, 32'h0);
    for (k = 0; k < 3; k++) begin
      o = 8'(k * 12);
      r = 32'h200 + ($random(seed) & 32'hff);
      wr(8'h02, 32'h0);
      wr(o + 8'h0c, 32'h20);
      wr(o + 8'h04, r);
      wr(o + 8'h08, 32'h0);
      wr(8'h02, 32'h1 << k);
      for (i = 0; i < 20 && underflowIrq[k] !== 1'b1; i++) begin
        @(posedge sys_clk);
        #1;
      end
      chk("underflow irq", {31'h0, underflowIrq[k]}, 32'h1);
      rd(o + 8'h0c);
      chk("underflow flag", d, 32'h120);
      rd(o + 8'h08);
      chk("reloaded", {31'h0, d <= r && d > r - 32'h10}, 32'h1);
      wr(o + 8'h0c, 32'h120);
      chk("flag kept", {31'h0, underflowIrq[k]}, 32'h1);
      wr(o + 8'h0c, 32'h100);
      chk("irq masked", {31'h0, underflowIrq[k]}, 32'h0);
      wr(o + 8'h0c, 32'h0);
      rd(o + 8'h0c);
      chk("flag cleared", d, 32'h0);
      wr(8'h02, 32'h0);
      wr(o + 8'h08, r);
      repeat (20) @(posedge sys_clk);
      rd(o + 8'h08);
      chk("halted", d, r);
    end
    for (k = 0; k < 4; k++) begin
      wr(8'h0c, 32'(k));
      wr(8'h08, 32'h10000);
      wr(8'h02, 32'h1);
      repeat (1024) @(posedge sys_clk);
      wr(8'h02, 32'h0);
      rd(8'h08);
      w = 32'h10000 - d;
      chk("prescale", {31'h0, w >= decExp(k) && w <= decExp(k) + 1}, 32'h1);
    end
    for (k = 0; k < 4; k++) begin
      pulses(32'({k[1:0], 3'b101}), 1'b1);
      chk("pin edges", d, k[1] ? 32'hfa : 32'hfd);
    end
    pulses(32'h4, 1'b0);
    chk("tick count", d, 32'hfd);
    w = $random(seed);
    wr(8'h24, 32'hc0);
    wr(8'h20, w);
    pins(1'b1, 1'b0);
    chk("capture irq", {31'h0, captureIrq}, 32'h1);
    rd(8'h28);
    chk("capture value", d, w);
    rd(8'h24);
    chk("capture flag", d, 32'h2c0);
    wr(8'h24, 32'h2c0);
    chk("flag write one", {31'h0, captureIrq}, 32'h1);
    wr(8'h24, 32'h88);
    chk("capture no irq", {31'h0, captureIrq}, 32'h0);
    w = $random(seed);
    wr(8'h20, w);
    pins(1'b0, 1'b0);
    rd(8'h24);
    chk("code 10 flag", d, 32'h288);
    chk("code 10 irq", {31'h0, captureIrq}, 32'h0);
    rd(8'h28);
    chk("falling capture", d, w);
    wr(8'h24, 32'h8);
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
    rd(8'h24);
    chk("capture off", d, 32'h8);
    wr(8'h0c, 32'h0);
    wr(8'h18, 32'h4);
    wr(8'h02, 32'h7);
    stby(3'b101);
    rd(8'h02);
    chk("stop clears run", d, 32'h2);
    wr(8'h02, 32'h7);
    stby(3'b110);
    rd(8'h02);
    chk("pll clears run", d, 32'h2);
    wr(8'h02, 32'h7);
    stby(3'b100);
    rd(8'h02);
    chk("standby keeps run", d, 32'h7);
    rd(8'h18);
    chk("ctrl kept", d, 32'h4);
    give_verdict();
  end

  // hang guard, well beyond the fewer than five thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge sys_clk);
    errorCnt++;
    give_verdict();
  end
endmodule : tb_tmr3_timer

// ### verification/tmr3_timer_monitor.sv
// assertion checker for the three channel timer block
`timescale 1ns/1ps
module tmr3_timer_monitor #(
  parameter int CHANNELS = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire tmr3_pkg::tmr3_bus_req_t busReq,
  input wire logic [31:0] rdData,
  // pin and tick
  input wire logic timerExtPinIn,
  input wire logic timerExtPinOut,
  input wire logic timerExtPinOe,
  input wire logic rtcTick,
  // standby and interrupts
  input wire tmr3_pkg::tmr3_standby_t standby,
  input wire logic [CHANNELS-1:0] underflowIrq,
  input wire logic captureIrq
);
  import tmr3_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_reset_quiet: assert property ($past(reset) |-> !timerExtPinOe &&
    !captureIrq && underflowIrq == '0 && rdData == 32'h0)
    else $error("outputs not quiet after reset");
  chk_pin_out_tick: assert property (!$past(reset) |->
    timerExtPinOut == $past(rtcTick)) else $error("pin out not tick");
  chk_dir_write_oe: assert property (busReq.wrStrobe &&
    busReq.addr == 8'h00 |=> timerExtPinOe == $past(busReq.wrData[0]))
    else $error("pin enable not set by write");
  chk_dir_readback: assert property (busReq.rdStrobe &&
    busReq.addr == 8'h00 |=> rdData == {31'h0, timerExtPinOe})
    else $error("direction read wrong");
  chk_run_reserved: assert property (busReq.rdStrobe &&
    busReq.addr == 8'h02 |=> rdData[31:3] == 29'h0)
    else $error("run reserved bits set");
  chk_ctrl_reserved: assert property (busReq.rdStrobe &&
    busReq.addr inside {8'h0c, 8'h18} |=> (rdData & 32'hfffffec0) == 32'h0)
    else $error("control reserved bits set");
  chk_underflow_irq_enable_gate: assert property (busReq.wrStrobe &&
    busReq.addr == 8'h0c && !busReq.wrData[5] |=> !underflowIrq[0])
    else $error("underflow irq not masked");
  chk_cap_irq_code: assert property (busReq.wrStrobe &&
    busReq.addr == 8'h24 && busReq.wrData[7:6] != 2'b11 |=> !captureIrq)
    else $error("capture irq without code 11");
  chk_irq_level: assert property (underflowIrq[0] &&
    !busReq.wrStrobe |=> underflowIrq[0]) else $error("underflow irq lost");
  chk_cap_hold: assert property (captureIrq && !busReq.wrStrobe |=>
    captureIrq) else $error("capture irq lost");
endmodule : tmr3_timer_monitor

bind tmr3_timer tmr3_timer_monitor #(.CHANNELS(CHANNELS)) uMon (
  .sys_clk(sys_clk), .reset(reset), .busReq(busReq), .rdData(rdData),
  .timerExtPinIn(timerExtPinIn), .timerExtPinOut(timerExtPinOut),
  .timerExtPinOe(timerExtPinOe), .rtcTick(rtcTick), .standby(standby),
  .underflowIrq(underflowIrq), .captureIrq(captureIrq));
